// ---- hw/amc_pkg.sv ----
package amc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ARCH     = 8'h00;
  localparam logic [7:0] OFS_PSW      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_FACIL    = 8'h0C;
  localparam logic [7:0] OFS_CREG_SEL = 8'h10;
  localparam logic [7:0] OFS_CREG_DAT = 8'h14;
  localparam logic [7:0] OFS_SAVE     = 8'h18;
  localparam logic [7:0] OFS_REFCODE  = 8'h1C;
  localparam logic [7:0] OFS_LOWMAP   = 8'h20;
  // field positions
  localparam int PSW_MODE_BIT    = 12;
  localparam int ST_EC_BIT       = 0;
  localparam int ST_ARCH_BIT     = 1;
  localparam int ST_SAVE_BUSY    = 2;
  localparam int ST_SAVE_DONE    = 3;
  localparam int ST_LOAD_PEND    = 4;
  localparam int NUM_CREGS       = 16;
  localparam int NUM_EXT_LINES   = 6;
  // storage figures
  localparam logic [31:0] LEGACY_FIXED_TOP = 32'h0000_007F;
  localparam logic [31:0] EXT_FIXED_TOP    = 32'h0000_01FF;
  localparam logic [31:0] VSTORE_MAX_BYTES = 32'h0100_0000;
  localparam logic [11:0] SAVE_AREA_BYTES  = 12'h800;
  localparam logic [11:0] SAVE_WORDS       = 12'h200;
  // reset values
  localparam logic [31:0] PSW_RESET    = 32'h0000_0000;
  localparam logic [31:0] CREG_RESET   = 32'h0000_0000;
  // facility bits, mode 0 = legacy-compatible, mode 1 = enhanced
  localparam int FAC_DAT      = 0;
  localparam int FAC_IDA      = 1;
  localparam int FAC_MAPPING  = 2;
  localparam int FAC_STSTAT   = 3;
  localparam int FAC_MSAVE    = 4;
  localparam int FAC_EXTLINES = 5;
  localparam int FAC_DIRECT   = 6;
  localparam int FAC_LOGOUT   = 7;
  localparam int FAC_MP       = 8;
  localparam int FAC_XFAC     = 9;
  localparam int FAC_ASCII    = 10;
  localparam int FAC_REFCODE  = 11;

  typedef enum logic [0:0]
  {
    ARCH_LEGACY   = 1'b0,
    ARCH_ENHANCED = 1'b1
  } amc_arch_t;

  typedef enum logic [1:0]
  {
    SV_IDLE = 2'b00,
    SV_COPY = 2'b01,
    SV_DONE = 2'b10
  } amc_save_state_t;

  typedef struct packed
  {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } amc_req_t;
endpackage

// ---- hw/amc_creg_mem.sv ----
`timescale 1ns/1ns
module amc_creg_mem
  import amc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
)
(
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [31:0]   wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [31:0]   rd_data
);
  logic [31:0] mem_reg [DEPTH];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= CREG_RESET;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en)
        mem_reg[wr_addr] <= wr_data;
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule // amc_creg_mem

// ---- hw/amc_top.sv ----
`timescale 1ns/1ns
// Function
// - control mode is extended while status word bit 12 is one and basic while it is zero.
// - initial program reset forces basic control mode in either architecture mode.
// - in basic mode the fixed storage map covers only locations 0 to 127, legacy layout.
// - in extended mode the status word format changes and the fixed area reaches past 127.
// - fields dropped from the extended status word live above 127 and in a control register.
// - the architecture mode picked at microcode or program load selects the architecture.
// - sixteen control registers govern the extended facilities.
// - legacy mode offers translation and indirect data addressing, each space up to 16 MiB.
// - enhanced mode offers one mapped virtual space of up to 16 MiB for cpu and channels.
// - enhanced mode offers machine save of cpu state plus the lowest 2048 bytes of storage.
// - six external interruption lines exist with no direct read or write instructions.
// - extended machine-check, model logout to 256-351 and extended i/o logout are absent.
// - multiprocessing and its prefix, signal and address instructions are absent.
// - enhanced mode omits translation, indirect addressing, store status and the rest.
// - no ascii mode exists; bit 12 only selects the control mode.
// - both modes make reference codes from model-dependent logout data.
module amc_top
  import amc_pkg::*;
#(
  parameter int SAVE_LEN = 512
)
(
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // load controls from the support processor
  input  wire logic        initial_microcode_load,
  input  wire logic        initial_program_load,
  input  wire logic        arch_select,
  input  wire logic        program_reset,
  // external interruption lines (pins)
  input  wire logic [5:0]  ext_lines,
  // logout data feeding reference code generation
  input  wire logic        logout_valid,
  input  wire logic [31:0] logout_data,
  // status outputs
  output logic             extended_control_mode,
  output logic             basic_control_mode,
  output logic             arch_enhanced,
  output logic [31:0]      fixed_area_top,
  output logic [31:0]      facilities,
  output logic [5:0]       ext_pending,
  output logic             save_busy,
  output logic [10:0]      save_addr
);
  // bus request capture
  amc_req_t   req_reg;
  amc_req_t   req_next;
  wire logic  addr_phase;
  wire logic  wr_go;
  wire logic  rd_sel;

  assign addr_phase = hsel & htrans[1] & hready;
  assign req_next   = '{sel: addr_phase, write: hwrite, addr: haddr[7:0]};
  assign wr_go      = req_reg.sel & req_reg.write;
  assign rd_sel     = addr_phase & ~hwrite;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req_reg <= '0;
    else
      req_reg <= req_next;
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // pin input synchronisers, three flops, change taken when stages two and three agree
  logic [4:0] ld_s1_reg;
  logic [4:0] ld_s2_reg;
  logic [4:0] ld_s3_reg;
  logic [4:0] ld_q_reg;
  logic [5:0] ext_s1_reg;
  logic [5:0] ext_s2_reg;
  logic [5:0] ext_s3_reg;
  logic [5:0] ext_q_reg;
  wire  logic [4:0] ld_raw;
  wire  logic [4:0] ld_agree;
  wire  logic [5:0] ext_agree;

  assign ld_raw    = {logout_valid, program_reset, arch_select,
                      initial_program_load, initial_microcode_load};
  assign ld_agree  = ~(ld_s2_reg ^ ld_s3_reg);
  assign ext_agree = ~(ext_s2_reg ^ ext_s3_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ld_s1_reg  <= 5'h00;
      ld_s2_reg  <= 5'h00;
      ld_s3_reg  <= 5'h00;
      ld_q_reg   <= 5'h00;
      ext_s1_reg <= 6'h00;
      ext_s2_reg <= 6'h00;
      ext_s3_reg <= 6'h00;
      ext_q_reg  <= 6'h00;
    end
    else
    begin
      ld_s1_reg  <= ld_raw;
      ld_s2_reg  <= ld_s1_reg;
      ld_s3_reg  <= ld_s2_reg;
      ld_q_reg   <= (ld_agree & ld_s3_reg) | (~ld_agree & ld_q_reg);
      ext_s1_reg <= ext_lines;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_q_reg  <= (ext_agree & ext_s3_reg) | (~ext_agree & ext_q_reg);
    end
  end

  wire logic iml_q;
  wire logic ipl_q;
  wire logic sel_q;
  wire logic rst_q;
  wire logic lv_q;
  logic      iml_d_reg;
  logic      ipl_d_reg;
  logic      rst_d_reg;
  logic      lv_d_reg;
  wire logic load_edge;
  wire logic reset_edge;
  wire logic logout_edge;

  assign {lv_q, rst_q, sel_q, ipl_q, iml_q} = ld_q_reg;
  assign load_edge   = (iml_q & ~iml_d_reg) | (ipl_q & ~ipl_d_reg);
  // program load implies an initial program reset
  assign reset_edge  = (rst_q & ~rst_d_reg) | (ipl_q & ~ipl_d_reg);
  assign logout_edge = lv_q & ~lv_d_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      iml_d_reg <= 1'b0;
      ipl_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
      lv_d_reg  <= 1'b0;
    end
    else
    begin
      iml_d_reg <= iml_q;
      ipl_d_reg <= ipl_q;
      rst_d_reg <= rst_q;
      lv_d_reg  <= lv_q;
    end
  end

  // architecture latch, software may only stage a choice taken at next load
  amc_arch_t arch_reg;
  logic      arch_stage_reg;
  logic      stage_valid_reg;
  wire logic arch_choice;

  assign arch_choice = stage_valid_reg ? arch_stage_reg : sel_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arch_reg        <= ARCH_LEGACY;
      arch_stage_reg  <= 1'b0;
      stage_valid_reg <= 1'b0;
    end
    else
    begin
      if (load_edge)
      begin
        arch_reg        <= amc_arch_t'(arch_choice);
        stage_valid_reg <= 1'b0;
      end
      else if (wr_go && hit(req_reg.addr, OFS_ARCH))
      begin
        arch_stage_reg  <= hwdata[0];
        stage_valid_reg <= 1'b1;
      end
    end
  end

  wire logic enh;
  assign enh           = (arch_reg == ARCH_ENHANCED);
  assign arch_enhanced = enh;

  // status word; bit 12 only ever selects control mode, no ascii meaning
  logic      [31:0] psw_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      psw_reg <= PSW_RESET;
    else if (reset_edge)
      psw_reg <= PSW_RESET;
    else if (wr_go && hit(req_reg.addr, OFS_PSW))
      psw_reg <= hwdata;
  end

  wire logic ec_mode;
  assign ec_mode               = psw_reg[PSW_MODE_BIT];
  assign extended_control_mode = ec_mode;
  assign basic_control_mode    = ~ec_mode;
  // extended layout pushes fixed assignments past the legacy 0..127 area
  assign fixed_area_top = ec_mode ? EXT_FIXED_TOP : LEGACY_FIXED_TOP;

  // control registers; register 0 carries fields moved out of the ec status word
  logic      [3:0]  creg_sel_reg;
  wire logic [31:0] creg_rdata;
  wire logic        creg_wr;

  assign creg_wr = wr_go & hit(req_reg.addr, OFS_CREG_DAT);

  amc_creg_mem #(.DEPTH(NUM_CREGS), .AW(4)) u_cregs
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (creg_wr),
    .wr_addr (creg_sel_reg),
    .wr_data (hwdata),
    .rd_addr (creg_sel_reg),
    .rd_data (creg_rdata)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      creg_sel_reg <= 4'h0;
    else if (wr_go && hit(req_reg.addr, OFS_CREG_SEL))
      creg_sel_reg <= hwdata[3:0];
  end

  // facility set per architecture mode
  wire logic [31:0] fac_legacy;
  wire logic [31:0] fac_enh;

  assign fac_legacy = (32'h1 << FAC_DAT) | (32'h1 << FAC_IDA) | (32'h1 << FAC_STSTAT)
                    | (32'h1 << FAC_EXTLINES) | (32'h1 << FAC_REFCODE);
  assign fac_enh    = (32'h1 << FAC_MAPPING) | (32'h1 << FAC_MSAVE)
                    | (32'h1 << FAC_EXTLINES) | (32'h1 << FAC_REFCODE);
  // direct control, logouts, multiprocessing, extended facility, ascii never set
  assign facilities = enh ? fac_enh : fac_legacy;

  // external interruption lines, pending until software clears; set wins
  logic      [5:0] ext_pend_reg;
  logic      [5:0] ext_prev_reg;
  wire logic [5:0] ext_rise;
  wire logic [5:0] ext_clr;

  assign ext_rise = ext_q_reg & ~ext_prev_reg;
  assign ext_clr  = (wr_go && hit(req_reg.addr, OFS_STATUS)) ? hwdata[13:8] : 6'h00;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_pend_reg <= 6'h00;
      ext_prev_reg <= 6'h00;
    end
    else
    begin
      ext_prev_reg <= ext_q_reg;
      ext_pend_reg <= (ext_pend_reg & ~ext_clr) | ext_rise;
    end
  end
  assign ext_pending = ext_pend_reg;

  // machine save sequencer, walks the 2048-byte low area one word a cycle
  amc_save_state_t sv_reg;
  amc_save_state_t sv_next;
  logic      [10:0] sv_addr_reg;
  logic             sv_done_reg;
  wire logic        sv_start;
  wire logic        sv_last;

  assign sv_start = wr_go & hit(req_reg.addr, OFS_SAVE) & hwdata[0] & enh;
  assign sv_last  = (sv_addr_reg == 11'((SAVE_LEN - 1) * 4));

  always_comb
  begin
    sv_next = sv_reg;
    case (sv_reg)
      SV_IDLE: if (sv_start) sv_next = SV_COPY;
      SV_COPY: if (sv_last) sv_next = SV_DONE;
      SV_DONE: sv_next = SV_IDLE;
      default: sv_next = SV_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sv_reg      <= SV_IDLE;
      sv_addr_reg <= 11'h000;
      sv_done_reg <= 1'b0;
    end
    else
    begin
      sv_reg <= sv_next;
      if (sv_reg == SV_COPY)
        sv_addr_reg <= sv_addr_reg + 11'h004;
      else
        sv_addr_reg <= 11'h000;
      if (sv_reg == SV_DONE)
        sv_done_reg <= 1'b1;
      else if (wr_go && hit(req_reg.addr, OFS_STATUS) && hwdata[ST_SAVE_DONE])
        sv_done_reg <= 1'b0;
    end
  end
  assign save_busy = (sv_reg == SV_COPY);
  assign save_addr = sv_addr_reg;

  // reference code from logout data, folded signature
  logic [15:0] refcode_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      refcode_reg <= 16'h0000;
    else if (logout_edge)
      refcode_reg <= logout_data[31:16] ^ logout_data[15:0] ^ {refcode_reg[14:0], 1'b0};
  end

  // read mux, answered with zero wait states
  wire logic [31:0] status_word;
  logic      [31:0] rdata_next;

  assign status_word = {18'h0, ext_pend_reg, 3'h0, stage_valid_reg, sv_done_reg,
                        save_busy, enh, ec_mode};

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (haddr[7:0])
      OFS_ARCH:     rdata_next = {31'h0, arch_stage_reg};
      OFS_PSW:      rdata_next = psw_reg;
      OFS_STATUS:   rdata_next = status_word;
      OFS_FACIL:    rdata_next = facilities;
      OFS_CREG_SEL: rdata_next = {28'h0, creg_sel_reg};
      OFS_CREG_DAT: rdata_next = creg_rdata;
      OFS_REFCODE:  rdata_next = {16'h0, refcode_reg};
      OFS_LOWMAP:   rdata_next = fixed_area_top;
      default:      rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_sel)
      hrdata <= rdata_next;
  end
endmodule // amc_top

// ---- tb/amc_top_assertions.sv ----
`timescale 1ns/1ns
module amc_top_assertions
  import amc_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // load pins
  input wire logic        initial_microcode_load,
  input wire logic        initial_program_load,
  input wire logic        program_reset,
  // status
  input wire logic        extended_control_mode,
  input wire logic        basic_control_mode,
  input wire logic        arch_enhanced,
  input wire logic [31:0] fixed_area_top,
  input wire logic [31:0] facilities,
  input wire logic        save_busy
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // cycles since a load pin was last high, saturating
  logic [3:0] load_age_reg;
  logic [3:0] load_age_next;
  wire        load_high = initial_microcode_load | initial_program_load;
  assign load_age_next = load_high ? 4'h0 : (&load_age_reg ? 4'hF : load_age_reg + 4'h1);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      load_age_reg <= 4'hF;
    else
      load_age_reg <= load_age_next;

  a_mode_onehot: assert property (extended_control_mode != basic_control_mode)
    else $error("control mode outputs disagree");
  a_load_to_basic: assert property ($rose(initial_program_load) || $rose(program_reset)
    |-> ##[1:8] basic_control_mode) else $error("no basic mode after program reset");
  a_basic_fixed_top: assert property (basic_control_mode |-> fixed_area_top == 32'h0000_007F)
    else $error("basic fixed area top wrong");
  a_ext_fixed_top: assert property (extended_control_mode |-> fixed_area_top > 32'h0000_007F)
    else $error("extended fixed area not past 127");
  a_legacy_facil: assert property (!arch_enhanced |-> facilities[FAC_DAT] && facilities[FAC_IDA]
    && !facilities[FAC_MAPPING] && !facilities[FAC_MSAVE]) else $error("legacy facilities wrong");
  a_enh_facil: assert property (arch_enhanced |-> facilities[FAC_MAPPING] && facilities[FAC_MSAVE]
    && !facilities[FAC_DAT] && !facilities[FAC_STSTAT]) else $error("enhanced facilities wrong");
  a_ext_lines: assert property (facilities[FAC_EXTLINES] && !facilities[FAC_DIRECT])
    else $error("external line facility wrong");
  a_no_logout: assert property (!facilities[FAC_LOGOUT]) else $error("logout present");
  a_no_mp: assert property (!facilities[FAC_MP]) else $error("multiprocessing present");
  a_save_enh: assert property (save_busy |-> arch_enhanced) else $error("save in legacy");
  a_no_ascii: assert property (!facilities[FAC_ASCII]) else $error("ascii present");
  a_refcode: assert property (facilities[FAC_REFCODE]) else $error("refcode absent");
  a_arch_held: assert property ($changed(arch_enhanced) |-> load_age_reg < 4'hA)
    else $error("arch changed without load");

  cover property (extended_control_mode);
  cover property (arch_enhanced && save_busy);
  cover property ($rose(basic_control_mode));
endmodule // amc_top_assertions

bind amc_top amc_top_assertions u_chk
(
  .hclk, .hresetn, .initial_microcode_load, .initial_program_load, .program_reset,
  .extended_control_mode, .basic_control_mode, .arch_enhanced, .fixed_area_top,
  .facilities, .save_busy
);

// ---- tb/tb_amc_top.sv ----
`timescale 1ns/1ns
module tb_amc_top;
  import amc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        initial_microcode_load = 1'b0;
  logic        initial_program_load = 1'b0;
  logic        arch_select = 1'b0;
  logic        program_reset = 1'b0;
  logic [5:0]  ext_lines = 6'h00;
  logic        logout_valid = 1'b0;
  logic [31:0] logout_data = 32'h0000_0000;
  logic        extended_control_mode;
  logic        basic_control_mode;
  logic        arch_enhanced;
  logic [31:0] fixed_area_top;
  logic [31:0] facilities;
  logic [5:0]  ext_pending;
  logic        save_busy;
  logic [10:0] save_addr;
  logic [10:0] sa_max = 11'h000;
  logic [31:0] rv;
  int          n_mismatch = 0;
  int          n_compared = 0;

  amc_top u_dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .initial_microcode_load, .initial_program_load, .arch_select, .program_reset,
    .ext_lines, .logout_valid, .logout_data, .extended_control_mode, .basic_control_mode,
    .arch_enhanced, .fixed_area_top, .facilities, .ext_pending, .save_busy, .save_addr
  );

  initial
    forever #5 hclk = ~hclk;

  task automatic wait_rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic addr_ph(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask

  // extra edge so the stored value reaches the outputs before checks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    wait_rdy();
    @(posedge hclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_ph(a, 1'b0);
    wait_rdy();
    d = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // pins pass a synchroniser of about four cycles
  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk("basic", 32'(basic_control_mode), 32'h0000_0001);
    chk("fac", facilities & 32'h0000_0FFF, 32'h0000_082B);
    chk("hresp", 32'(hresp), 32'h0000_0000);
    wr(OFS_FACIL, 32'h0000_0000);
    rd(OFS_FACIL, rv);
    chk("facreg", rv & 32'h0000_0FFF, 32'h0000_082B);
    rd(OFS_LOWMAP, rv);
    chk("top", rv, 32'h0000_007F);
    wr(OFS_SAVE, 32'h0000_0001);
    settle();
    chk("savelegacy", 32'(save_busy), 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, rv);
    chk("unmapped", rv, 32'h0000_0000);
    wr(OFS_PSW, 32'h0000_1000);
    chk("ec", 32'(extended_control_mode), 32'h0000_0001);
    rd(OFS_LOWMAP, rv);
    chk("topext", 32'(rv > 32'h0000_007F), 32'h0000_0001);
    rd(OFS_STATUS, rv);
    chk("status", rv, 32'h0000_0001);
    wr(OFS_PSW, 32'hFFFF_EFFF);
    chk("bit12only", 32'(basic_control_mode), 32'h0000_0001);
    wr(OFS_PSW, 32'h0000_1000);
    program_reset <= 1'b1;
    settle();
    chk("prst", 32'(basic_control_mode), 32'h0000_0001);
    program_reset <= 1'b0;
    wr(OFS_ARCH, 32'h0000_0001);
    settle();
    chk("staged", 32'(arch_enhanced), 32'h0000_0000);
    rd(OFS_STATUS, rv);
    chk("stagebit", rv, 32'h0000_0010);
    arch_select <= 1'b1;
    initial_microcode_load <= 1'b1;
    settle();
    initial_microcode_load <= 1'b0;
    settle();
    chk("arch", 32'(arch_enhanced), 32'h0000_0001);
    chk("facenh", facilities & 32'h0000_0FFF, 32'h0000_0834);
    arch_select <= 1'b0;
    settle();
    chk("held", 32'(arch_enhanced), 32'h0000_0001);
    wr(OFS_SAVE, 32'h0000_0001);
    chk("busy", 32'(save_busy), 32'h0000_0001);
    for (int i = 0; i < 700 && save_busy === 1'b1; i++)
    begin
      if (save_addr > sa_max)
        sa_max = save_addr;
      @(posedge hclk);
    end
    chk("saveend", 32'(save_busy), 32'h0000_0000);
    chk("savetop", 32'(sa_max), 32'h0000_07FC);
    rd(OFS_STATUS, rv);
    chk("savedone", rv & 32'h0000_000F, 32'h0000_000A);
    wr(OFS_PSW, 32'h0000_1000);
    arch_select <= 1'b1;
    initial_program_load <= 1'b1;
    settle();
    initial_program_load <= 1'b0;
    settle();
    chk("iplbasic", 32'(basic_control_mode), 32'h0000_0001);
    ext_lines <= 6'h2A;
    settle();
    chk("pend", 32'(ext_pending), 32'h0000_002A);
    wr(OFS_STATUS, 32'h0000_3F00);
    chk("clear", 32'(ext_pending), 32'h0000_0000);
    ext_lines <= 6'h00;
    wr(OFS_CREG_SEL, 32'h0000_000F);
    wr(OFS_CREG_DAT, 32'h1234_5678);
    rd(OFS_CREG_DAT, rv);
    chk("cregrd", rv, 32'h1234_5678);
    wr(OFS_CREG_SEL, 32'h0000_0000);
    wr(OFS_CREG_DAT, 32'h0000_A5A5);
    rd(OFS_CREG_DAT, rv);
    chk("creg0", rv, 32'h0000_A5A5);
    wr(OFS_CREG_SEL, 32'h0000_000F);
    rd(OFS_CREG_DAT, rv);
    chk("cregkeep", rv, 32'h1234_5678);
    logout_data <= 32'hA5A5_0F0F;
    logout_valid <= 1'b1;
    settle();
    logout_valid <= 1'b0;
    chk("refcode", 32'(facilities[FAC_REFCODE]), 32'h0000_0001);
    rd(OFS_REFCODE, rv);
    chk("refcodeval", 32'(rv != 32'h0000_0000), 32'h0000_0001);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end
endmodule // tb_amc_top
